// File: byte_eeprom_access_controller_tb.sv
// Testbench joining the CPU end and the EEPROM controller
`timescale 1ns/1ps
module byte_eeprom_access_controller_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        osc_tick = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [31:0] rd;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          stall_cycles = 0;
  int          stall_expect = 0;
  logic [1:0]  opv [6] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
  logic [8:0]  adv [6] = '{9'h1a5, 9'h1a5, 9'h1a5, 9'h1a5, 9'h000, 9'h1ff};
  logic [7:0]  dav [6] = '{8'h3c, 8'h00, 8'h5a, 8'h0f, 8'hc3, 8'h81};
  logic [7:0]  exv [6] = '{8'h3c, 8'hff, 8'h5a, 8'h0a, 8'hc3, 8'h81};

  always #2 ref_clk = ~ref_clk;
  // Oscillator ticks, unrelated to the CPU clock
  always #19.3 osc_tick = ~osc_tick;

  eeprom_io_if eeprom_io_if_i (.ref_clk(ref_clk));
  eeprom_host eeprom_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .io(eeprom_io_if_i),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  eeprom_dev #(.ATOMIC_TICKS(6), .SPLIT_TICKS(3)) eeprom_dev_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .io(eeprom_io_if_i), .osc_tick(osc_tick));
  eeprom_io_chk eeprom_io_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .io_addr(eeprom_io_if_i.io_addr), .io_wdata(eeprom_io_if_i.io_wdata),
    .io_wr(eeprom_io_if_i.io_wr), .io_rd(eeprom_io_if_i.io_rd),
    .io_rdata(eeprom_io_if_i.io_rdata), .cpu_stall(eeprom_io_if_i.cpu_stall),
    .ready_irq(eeprom_io_if_i.ready_irq), .global_irq_en(eeprom_io_if_i.global_irq_en));

  always @(posedge ref_clk) begin
    if (eeprom_io_if_i.cpu_stall === 1'b1) begin
      stall_cycles++;
    end
  end

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (waitrequest !== 1'b0) begin
      mismatches++;
      $display("MISMATCH waitrequest expected 0 seen 1");
      print_verdict();
    end
  endtask

  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    wait_ack();
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    wait_ack();
    d = readdata;
    read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic run_op(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    av_wr(eeprom_pkg::HOST_ADDR, {23'h0, a});
    av_wr(eeprom_pkg::HOST_DATA, {24'h0, d});
    av_wr(eeprom_pkg::HOST_CMD, {30'h0, op});
    stall_expect += (op == eeprom_pkg::OP_READ) ? 4 : 2;
    do begin
      av_rd(eeprom_pkg::HOST_STATUS, rd);
      n++;
    end while (rd[eeprom_pkg::ST_DONE] !== 1'b1 && n < 500);
    check("done", {31'h0, rd[eeprom_pkg::ST_DONE]}, 32'h1);
    av_wr(eeprom_pkg::HOST_STATUS, 32'h2);
  endtask

  task automatic rd_byte(input logic [8:0] a, input logic [7:0] exp);
    run_op(eeprom_pkg::OP_READ, a, 8'h00);
    av_rd(eeprom_pkg::HOST_RDATA, rd);
    check("byte", rd, {24'h0, exp});
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    av_rd(eeprom_pkg::HOST_STATUS, rd);
    check("status", rd, 32'h0);
    av_wr(5'h1c, 32'hffffffff);
    av_rd(5'h1c, rd);
    check("unmapped", rd, 32'h0);
    // Every mode, an unerased write and both address ends
    for (int i = 0; i < 6; i++) begin
      run_op(opv[i], adv[i], dav[i]);
      rd_byte(adv[i], exv[i]);
    end
    // Ready interrupt for each enable pair; enable lands with a command
    for (int i = 0; i < 4; i++) begin
      av_wr(eeprom_pkg::HOST_CFG, i);
      rd_byte(9'h000, 8'hc3);
      av_rd(eeprom_pkg::HOST_STATUS, rd);
      av_rd(eeprom_pkg::HOST_STATUS, rd);
      check("ready irq", {31'h0, rd[eeprom_pkg::ST_IRQ]}, {31'h0, i == 3});
    end
    rd_byte(9'h000, 8'hc3);
    check("stall cycles", stall_cycles, stall_expect);
    print_verdict();
  end
endmodule

// File: eeprom_dev.sv
// EEPROM controller: I/O registers, stalls, timed programming and array
// Operation
// - 512-byte data array, byte read and write
// - Address, data, control registers on I/O bus
// - Read stalls the CPU four cycles
// - Program start stalls the CPU two cycles
// - Host loads address and data first
// - Mode 00, armed strobe: erase then write
// - Strobe reads one until combined op ends
// - No other operation while programming
// - Mode 01, armed strobe: erase only
// - Strobe held until erase completes
// - Mode 10, armed strobe: write only
// - Strobe held until write completes
// - Host erases before a write-only operation; eeprom_host issues mode 10 unerased, so the write ANDs into the old byte
// - Programming self-timed, strobe polled as busy
// - Durations counted on oscillator ticks
// - Host waits strobe zero, then arms, strobes
// - Read strobe loads addressed byte into data
// - 3.4 ms combined, 1.8 ms split; 11 reserved
// - Arm clears after four cycles; needed
// - Mode locked while busy; reset to 00 unless busy
// - Ready interrupt level when enabled and idle
`timescale 1ns/1ps
module eeprom_dev #(
  parameter int ATOMIC_TICKS = eeprom_pkg::ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = eeprom_pkg::SPLIT_TICKS
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // CPU I/O bus
  eeprom_io_if.dev  io,
  // Calibrated oscillator, one edge per tick
  input  wire logic osc_tick
);

  // ********************
  // State
  // ********************
  logic [7:0]                         mem [eeprom_pkg::EE_BYTES];
  logic [eeprom_pkg::ADDR_W-1:0]      addr_reg;
  logic [7:0]                         data_reg;
  logic [1:0]                         mode;
  logic                               rie;
  logic                               arm;
  logic [2:0]                         arm_cnt;
  logic                               prog;
  logic                               read_strobe;
  logic [1:0]                         op_mode;
  logic [eeprom_pkg::ADDR_W-1:0]      op_addr;
  logic [7:0]                         op_data;
  logic [eeprom_pkg::TICK_W-1:0]      ticks;
  logic [2:0]                         stall_cnt;
  logic [2:0]                         next_stall_cnt;
  logic                               osc_meta;
  logic                               osc_sync;
  logic                               osc_prev;
  logic                               tick;
  logic                               wr_ctrl;
  logic [1:0]                         wr_mode;
  logic                               start_prog;
  logic                               start_read;
  logic                               prog_end;

  // ********************
  // Decode
  // ********************
  assign wr_ctrl    = io.io_wr && io.io_addr == eeprom_pkg::IO_CTRL;
  assign wr_mode    = io.io_wdata[eeprom_pkg::CTRL_MODE_HI:eeprom_pkg::CTRL_MODE_LO];
  assign start_prog = wr_ctrl && io.io_wdata[eeprom_pkg::CTRL_PROG] && arm && !prog &&
                      wr_mode != eeprom_pkg::MODE_RSVD;
  assign start_read = wr_ctrl && io.io_wdata[eeprom_pkg::CTRL_READ] && !prog &&
                      !start_prog;
  assign prog_end   = prog && tick && ticks == eeprom_pkg::TICK_W'(1);

  // ********************
  // Oscillator tick
  // ********************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= osc_tick;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  assign tick = osc_sync && !osc_prev;

  // ********************
  // Programming engine
  // ********************
  // An operation under way survives reset, its tick count held while in reset; an unknown busy state
  // falls to the idle branch, so the flag is defined after reset
  always_ff @(posedge ref_clk) begin
    if (prog) begin
      if (prog_end) begin
        prog <= 1'b0;
      end else if (tick) begin
        ticks <= ticks - eeprom_pkg::TICK_W'(1);
      end
    end else if (rst_n && start_prog) begin
      prog    <= 1'b1;
      op_mode <= wr_mode;
      op_addr <= addr_reg;
      op_data <= data_reg;
      if (wr_mode == eeprom_pkg::MODE_ATOMIC) begin
        ticks <= eeprom_pkg::TICK_W'(ATOMIC_TICKS);
      end else begin
        ticks <= eeprom_pkg::TICK_W'(SPLIT_TICKS);
      end
    end else begin
      prog    <= 1'b0;
      op_mode <= eeprom_pkg::MODE_ATOMIC;
      op_addr <= '0;
      op_data <= 8'h00;
      ticks   <= '0;
    end
  end

  // ********************
  // Array
  // ********************
  always_ff @(posedge ref_clk) begin
    if (prog_end) begin
      unique case (op_mode)
        eeprom_pkg::MODE_ATOMIC: mem[op_addr] <= op_data;
        eeprom_pkg::MODE_ERASE:  mem[op_addr] <= eeprom_pkg::ERASED;
        eeprom_pkg::MODE_WRITE:  mem[op_addr] <= mem[op_addr] & op_data;
        default:                 mem[op_addr] <= mem[op_addr];
      endcase
    end
  end

  // ********************
  // Control register
  // ********************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      if (prog) begin
        mode <= mode;
      end else begin
        mode <= eeprom_pkg::MODE_ATOMIC;
      end
    end else if (wr_ctrl && !prog) begin
      mode <= wr_mode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rie <= 1'b0;
    end else if (wr_ctrl) begin
      rie <= io.io_wdata[eeprom_pkg::CTRL_RIE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arm     <= 1'b0;
      arm_cnt <= 3'h0;
    end else if (start_prog) begin
      arm     <= 1'b0;
      arm_cnt <= 3'h0;
    end else if (wr_ctrl && io.io_wdata[eeprom_pkg::CTRL_ARM]) begin
      arm     <= 1'b1;
      arm_cnt <= eeprom_pkg::ARM_CYCLES;
    end else if (arm) begin
      arm_cnt <= arm_cnt - 3'h1;
      if (arm_cnt == 3'h1) begin
        arm <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      read_strobe <= 1'b0;
    end else begin
      read_strobe <= start_read;
    end
  end

  // ********************
  // Address and data
  // ********************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_reg <= '0;
    end else if (io.io_wr && io.io_addr == eeprom_pkg::IO_ADDR_HIGH) begin
      addr_reg[eeprom_pkg::ADDR_W-1] <= io.io_wdata[0];
    end else if (io.io_wr && io.io_addr == eeprom_pkg::IO_ADDR_LOW) begin
      addr_reg[7:0] <= io.io_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_reg <= 8'h00;
    end else if (read_strobe) begin
      data_reg <= mem[addr_reg];
    end else if (io.io_wr && io.io_addr == eeprom_pkg::IO_DATA) begin
      data_reg <= io.io_wdata;
    end
  end

  // ********************
  // CPU stall
  // ********************
  always_comb begin
    if (start_read) begin
      next_stall_cnt = eeprom_pkg::READ_STALL;
    end else if (start_prog) begin
      next_stall_cnt = eeprom_pkg::PROG_STALL;
    end else if (stall_cnt != 3'h0) begin
      next_stall_cnt = stall_cnt - 3'h1;
    end else begin
      next_stall_cnt = 3'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stall_cnt    <= 3'h0;
      io.cpu_stall <= 1'b0;
    end else begin
      stall_cnt    <= next_stall_cnt;
      io.cpu_stall <= next_stall_cnt != 3'h0;
    end
  end

  // ********************
  // Read port and interrupt
  // ********************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      io.io_rdata <= 8'h00;
    end else if (io.io_rd) begin
      unique case (io.io_addr)
        eeprom_pkg::IO_ADDR_HIGH: io.io_rdata <= {7'h00, addr_reg[eeprom_pkg::ADDR_W-1]};
        eeprom_pkg::IO_ADDR_LOW:  io.io_rdata <= addr_reg[7:0];
        eeprom_pkg::IO_DATA:      io.io_rdata <= data_reg;
        eeprom_pkg::IO_CTRL:      io.io_rdata <= {2'h0, mode, rie, arm, prog, read_strobe};
        default:                  io.io_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      io.ready_irq <= 1'b0;
    end else begin
      io.ready_irq <= rie && io.global_irq_en && !prog;
    end
  end

endmodule

// File: eeprom_host.sv
// CPU end: runs EEPROM sequences on the I/O bus on Avalon-MM commands
`timescale 1ns/1ps
module eeprom_host (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // I/O bus
  eeprom_io_if.cpu         io,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest
);

  typedef enum logic [3:0] {
    S_IDLE, S_POLL, S_POLL_CHK, S_MODE, S_ADDR_H, S_ADDR_L,
    S_DATA, S_ARM, S_PROG, S_RD_STROBE, S_RD_DATA, S_RD_CAP
  } host_state_e;

  host_state_e                    state;
  logic [1:0]                     op;
  logic [1:0]                     op_mode;
  logic [eeprom_pkg::ADDR_W-1:0]  cmd_addr;
  logic [7:0]                     cmd_data;
  logic [7:0]                     rd_result;
  logic                           cfg_gie;
  logic                           cfg_rie;
  logic                           done;
  logic                           ee_busy;
  logic                           issued;
  logic                           go;
  logic                           wr_take;
  logic                           cmd_start;
  logic                           finish;

  // ********************
  // Avalon-MM slave
  // ********************
  assign wr_take   = write && !waitrequest;
  assign cmd_start = wr_take && address == eeprom_pkg::HOST_CMD && state == S_IDLE;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= 32'h0;
      if (read) begin
        unique case (address)
          eeprom_pkg::HOST_ADDR:   readdata[eeprom_pkg::ADDR_W-1:0] <= cmd_addr;
          eeprom_pkg::HOST_DATA:   readdata[7:0] <= cmd_data;
          eeprom_pkg::HOST_RDATA:  readdata[7:0] <= rd_result;
          eeprom_pkg::HOST_CFG: begin
            readdata[eeprom_pkg::CFG_GIE] <= cfg_gie;
            readdata[eeprom_pkg::CFG_RIE] <= cfg_rie;
          end
          eeprom_pkg::HOST_STATUS: begin
            readdata[eeprom_pkg::ST_BUSY]    <= state != S_IDLE;
            readdata[eeprom_pkg::ST_DONE]    <= done;
            readdata[eeprom_pkg::ST_EE_BUSY] <= ee_busy;
            readdata[eeprom_pkg::ST_IRQ]     <= io.ready_irq;
          end
          default: readdata <= 32'h0;
        endcase
      end
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_addr <= '0;
      cmd_data <= 8'h00;
      cfg_gie  <= 1'b0;
      cfg_rie  <= 1'b0;
    end else if (wr_take && address == eeprom_pkg::HOST_ADDR) begin
      cmd_addr <= writedata[eeprom_pkg::ADDR_W-1:0];
    end else if (wr_take && address == eeprom_pkg::HOST_DATA) begin
      cmd_data <= writedata[7:0];
    end else if (wr_take && address == eeprom_pkg::HOST_CFG) begin
      cfg_gie <= writedata[eeprom_pkg::CFG_GIE];
      cfg_rie <= writedata[eeprom_pkg::CFG_RIE];
    end
  end

  // Completion flag, set wins over the write-one clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (finish) begin
      done <= 1'b1;
    end else if (wr_take && address == eeprom_pkg::HOST_STATUS &&
                 writedata[eeprom_pkg::ST_DONE]) begin
      done <= 1'b0;
    end
  end

  // ********************
  // Sequencer
  // ********************
  // One idle cycle after each access, and none while the CPU is stalled
  assign go     = !issued && !io.cpu_stall;
  assign finish = go && (state == S_PROG || state == S_RD_CAP);

  always_comb begin
    unique case (op)
      eeprom_pkg::OP_ERASE: op_mode = eeprom_pkg::MODE_ERASE;
      eeprom_pkg::OP_WRITE: op_mode = eeprom_pkg::MODE_WRITE;
      default:              op_mode = eeprom_pkg::MODE_ATOMIC;
    endcase
  end

  function automatic logic [7:0] ctrl_byte(input logic arm, input logic prog, input logic rd);
    logic [7:0] b;
    b = 8'h00;
    b[eeprom_pkg::CTRL_MODE_HI:eeprom_pkg::CTRL_MODE_LO] = op_mode;
    b[eeprom_pkg::CTRL_RIE]  = cfg_rie;
    b[eeprom_pkg::CTRL_ARM]  = arm;
    b[eeprom_pkg::CTRL_PROG] = prog;
    b[eeprom_pkg::CTRL_READ] = rd;
    return b;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state            <= S_IDLE;
      op               <= eeprom_pkg::OP_READ;
      issued           <= 1'b0;
      ee_busy          <= 1'b0;
      rd_result        <= 8'h00;
      io.io_wr         <= 1'b0;
      io.io_rd         <= 1'b0;
      io.io_addr       <= 6'h00;
      io.io_wdata      <= 8'h00;
      io.global_irq_en <= 1'b0;
    end else begin
      io.global_irq_en <= cfg_gie;
      io.io_wr         <= 1'b0;
      io.io_rd         <= 1'b0;
      issued           <= 1'b0;
      if (state == S_IDLE) begin
        if (cmd_start) begin
          op    <= writedata[1:0];
          state <= S_POLL;
        end
      end else if (go) begin
        issued <= state != S_POLL_CHK;
        unique case (state)
          S_POLL: begin
            io.io_rd   <= 1'b1;
            io.io_addr <= eeprom_pkg::IO_CTRL;
            state      <= S_POLL_CHK;
          end
          S_POLL_CHK: begin
            ee_busy <= io.io_rdata[eeprom_pkg::CTRL_PROG];
            if (io.io_rdata[eeprom_pkg::CTRL_PROG]) begin
              state <= S_POLL;
            end else if (op == eeprom_pkg::OP_READ) begin
              state <= S_ADDR_H;
            end else begin
              state <= S_MODE;
            end
          end
          S_MODE: begin
            io.io_wr    <= 1'b1;
            io.io_addr  <= eeprom_pkg::IO_CTRL;
            io.io_wdata <= ctrl_byte(1'b0, 1'b0, 1'b0);
            state       <= S_ADDR_H;
          end
          S_ADDR_H: begin
            io.io_wr    <= 1'b1;
            io.io_addr  <= eeprom_pkg::IO_ADDR_HIGH;
            io.io_wdata <= {7'h00, cmd_addr[eeprom_pkg::ADDR_W-1]};
            state       <= S_ADDR_L;
          end
          S_ADDR_L: begin
            io.io_wr    <= 1'b1;
            io.io_addr  <= eeprom_pkg::IO_ADDR_LOW;
            io.io_wdata <= cmd_addr[7:0];
            state       <= (op == eeprom_pkg::OP_READ) ? S_RD_STROBE : S_DATA;
          end
          S_DATA: begin
            io.io_wr    <= 1'b1;
            io.io_addr  <= eeprom_pkg::IO_DATA;
            io.io_wdata <= cmd_data;
            state       <= S_ARM;
          end
          S_ARM: begin
            io.io_wr    <= 1'b1;
            io.io_addr  <= eeprom_pkg::IO_CTRL;
            io.io_wdata <= ctrl_byte(1'b1, 1'b0, 1'b0);
            state       <= S_PROG;
          end
          S_PROG: begin
            io.io_wr    <= 1'b1;
            io.io_addr  <= eeprom_pkg::IO_CTRL;
            io.io_wdata <= ctrl_byte(1'b1, 1'b1, 1'b0);
            state       <= S_IDLE;
          end
          S_RD_STROBE: begin
            io.io_wr    <= 1'b1;
            io.io_addr  <= eeprom_pkg::IO_CTRL;
            io.io_wdata <= ctrl_byte(1'b0, 1'b0, 1'b1);
            state       <= S_RD_DATA;
          end
          S_RD_DATA: begin
            io.io_rd   <= 1'b1;
            io.io_addr <= eeprom_pkg::IO_DATA;
            state      <= S_RD_CAP;
          end
          S_RD_CAP: begin
            rd_result <= io.io_rdata;
            state     <= S_IDLE;
            issued    <= 1'b0;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

endmodule

// File: eeprom_io_chk.sv
// Assertions on the CPU I/O bus between the two ends
`timescale 1ns/1ps
module eeprom_io_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // I/O bus
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic       cpu_stall,
  input wire logic       ready_irq,
  input wire logic       global_irq_en
);
  localparam int MINC = 19;
  logic [7:0] since;
  logic       ctl_wr;
  logic       ctl_rd;
  logic       start;
  assign ctl_wr = io_wr && io_addr == eeprom_pkg::IO_CTRL;
  assign ctl_rd = io_rd && io_addr == eeprom_pkg::IO_CTRL;
  assign start  = ctl_wr && io_wdata[2:1] == 2'h3;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence read_go;
    ctl_wr && io_wdata[1:0] == 2'h1;
  endsequence
  sequence prog_go;
    start;
  endsequence
  // Cycles since the last program start, saturating
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      since <= 8'hff;
    end else if (start) begin
      since <= 8'h00;
    end else if (since != 8'hff) begin
      since <= since + 8'h01;
    end
  end
  a_read_stall: assert property (read_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("Read stall is not four cycles");
  a_prog_stall: assert property (prog_go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("Program stall is not two cycles");
  a_rsvd_zero: assert property (ctl_rd |=> io_rdata[7:6] == 2'h0)
    else $error("Reserved control bits read nonzero");
  a_strobe_clr: assert property (ctl_rd |=> !io_rdata[eeprom_pkg::CTRL_READ])
    else $error("Read strobe still set");
  a_busy_held: assert property (ctl_rd && since > 0 && since < MINC |=> io_rdata[1])
    else $error("Program strobe cleared too early");
  a_irq_gate: assert property (ready_irq |-> $past(global_irq_en))
    else $error("Ready interrupt without global enable");
  a_irq_busy: assert property (since > 3 && since < MINC |-> !ready_irq)
    else $error("Ready interrupt while programming");
  a_rdata_hold: assert property (!$past(io_rd) |-> $stable(io_rdata))
    else $error("Read data changed without a read");
endmodule

// File: eeprom_io_if.sv
// CPU I/O bus between the CPU end and the EEPROM controller
`timescale 1ns/1ps
interface eeprom_io_if (
  input wire logic ref_clk
);
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_rdata;
  logic       cpu_stall;
  logic       ready_irq;
  logic       global_irq_en;

  modport dev (
    input  io_addr, io_wdata, io_wr, io_rd, global_irq_en,
    output io_rdata, cpu_stall, ready_irq
  );

  modport cpu (
    input  io_rdata, cpu_stall, ready_irq,
    output io_addr, io_wdata, io_wr, io_rd, global_irq_en
  );
endinterface

// File: eeprom_pkg.sv
// Shared constants for the byte EEPROM access controller and its CPU end
package eeprom_pkg;

  // ********************
  // Array
  // ********************
  localparam int          EE_BYTES = 512;
  localparam int          ADDR_W   = 9;
  localparam logic [7:0]  ERASED   = 8'hff;

  // ********************
  // I/O register map
  // ********************
  localparam logic [5:0]  IO_ADDR_HIGH = 6'h1f;
  localparam logic [5:0]  IO_ADDR_LOW  = 6'h1e;
  localparam logic [5:0]  IO_DATA      = 6'h1d;
  localparam logic [5:0]  IO_CTRL      = 6'h1c;

  // Control byte fields
  localparam int CTRL_READ    = 0;
  localparam int CTRL_PROG    = 1;
  localparam int CTRL_ARM     = 2;
  localparam int CTRL_RIE     = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_MODE_HI = 5;

  localparam logic [1:0]  MODE_ATOMIC = 2'h0;
  localparam logic [1:0]  MODE_ERASE  = 2'h1;
  localparam logic [1:0]  MODE_WRITE  = 2'h2;
  localparam logic [1:0]  MODE_RSVD   = 2'h3;

  // ********************
  // Timing
  // ********************
  localparam logic [2:0]  ARM_CYCLES  = 3'h4;
  localparam logic [2:0]  READ_STALL  = 3'h4;
  localparam logic [2:0]  PROG_STALL  = 3'h2;
  localparam int          OSC_KHZ     = 8000;
  localparam int          ATOMIC_US   = 3400;
  localparam int          SPLIT_US    = 1800;
  localparam int          ATOMIC_TICKS = ATOMIC_US * OSC_KHZ / 1000;
  localparam int          SPLIT_TICKS  = SPLIT_US * OSC_KHZ / 1000;
  localparam int          TICK_W      = 16;

  // ********************
  // CPU end Avalon-MM map
  // ********************
  localparam logic [4:0]  HOST_CMD    = 5'h00;
  localparam logic [4:0]  HOST_ADDR   = 5'h04;
  localparam logic [4:0]  HOST_DATA   = 5'h08;
  localparam logic [4:0]  HOST_STATUS = 5'h0c;
  localparam logic [4:0]  HOST_RDATA  = 5'h10;
  localparam logic [4:0]  HOST_CFG    = 5'h14;

  localparam logic [1:0]  OP_READ   = 2'h0;
  localparam logic [1:0]  OP_ATOMIC = 2'h1;
  localparam logic [1:0]  OP_ERASE  = 2'h2;
  localparam logic [1:0]  OP_WRITE  = 2'h3;

  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_EE_BUSY = 2;
  localparam int ST_IRQ     = 3;
  localparam int CFG_GIE    = 0;
  localparam int CFG_RIE    = 1;

endpackage
